// file: rtl/sbp_top.sv
// Serial boot loader and one-time memory programming engine
`timescale 1ns/10ps
`default_nettype none
`include "sbp_defines.svh"
module sbp_top #(
  parameter int TICK_DIV = `SBP_TICK_CYCLES,
  parameter int LOADER_LEN = `SBP_LOADER_LEN
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic rxd,
  output logic txd,
  output logic portc0,
  output logic prog_active,
  output logic rx_overrun,
  output logic [`SBP_ADDR_W-1:0] nvm_addr,
  output logic [`SBP_DATA_W-1:0] nvm_wdata,
  output logic nvm_wr,
  output logic nvm_rd,
  input wire logic [`SBP_DATA_W-1:0] nvm_rdata,
  input wire logic nvm_ack
);
  sbp_pkg::sbp_state_t state_r;
  logic rxd_m_r;
  logic rxd_s_r;
  logic [`SBP_TICK_W-1:0] div_r;
  logic tick;
  logic rx_act_r;
  logic [3:0] rx_ph_r;
  logic [3:0] rx_bit_r;
  logic [7:0] rx_sh_r;
  logic rx_push_r;
  logic fifo_in_ready;
  logic fifo_valid;
  logic fifo_pop;
  logic [`SBP_DATA_W-1:0] fifo_data;
  logic tx_busy_r;
  logic [3:0] tx_ph_r;
  logic [3:0] tx_bit_r;
  logic [8:0] tx_sh_r;
  logic [7:0] tx_data_r;
  logic tx_start;
  logic [7:0] tx_byte;
  logic [`SBP_CNT_W-1:0] load_cnt_r;
  logic [`SBP_DATA_W-1:0] rb_r;
  logic txd_r;
  logic portc0_r;
  logic prog_active_r;
  logic overrun_r;
  logic [`SBP_ADDR_W-1:0] addr_r;
  logic [`SBP_DATA_W-1:0] wdata_r;
  logic wr_r;
  logic rd_r;

  assign txd = txd_r;
  assign portc0 = portc0_r;
  assign prog_active = prog_active_r;
  assign rx_overrun = overrun_r;
  assign nvm_addr = addr_r;
  assign nvm_wdata = wdata_r;
  assign nvm_wr = wr_r;
  assign nvm_rd = rd_r;

  // ==========================================
  // Pin synchroniser and oversampling tick
  always_ff @(posedge clk) begin
    if (srst) begin
      rxd_m_r <= 1'b1;
      rxd_s_r <= 1'b1;
    end else begin
      rxd_m_r <= rxd;
      rxd_s_r <= rxd_m_r;
    end
  end

  assign tick = (div_r == `SBP_TICK_W'(TICK_DIV - 1));

  always_ff @(posedge clk) begin
    if (srst || tick) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
    end
  end

  // ==========================================
  // Receiver: samples mid-bit, false starts dropped
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_act_r <= 1'b0;
      rx_ph_r <= '0;
      rx_bit_r <= '0;
      rx_sh_r <= '0;
      rx_push_r <= 1'b0;
    end else begin
      rx_push_r <= 1'b0;
      if (!rx_act_r) begin
        if (tick && !rxd_s_r) begin
          rx_act_r <= 1'b1;
          rx_ph_r <= '0;
          rx_bit_r <= '0;
        end
      end else if (tick) begin
        rx_ph_r <= rx_ph_r + 1'b1;
        if (rx_ph_r == 4'h7) begin
          rx_bit_r <= rx_bit_r + 1'b1;
          if (rx_bit_r == 4'h0 && rxd_s_r) begin
            rx_act_r <= 1'b0;
          end else if (rx_bit_r == 4'h9) begin
            rx_act_r <= 1'b0;
            rx_push_r <= rxd_s_r;
          end else if (rx_bit_r != 4'h0) begin
            rx_sh_r <= {rxd_s_r, rx_sh_r[7:1]};
          end
        end
      end
    end
  end

  // Queue lets the next byte arrive while one is programmed
  sbp_fifo #(
    .WIDTH(`SBP_DATA_W),
    .DEPTH(`SBP_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .srst(srst),
    .in_valid(rx_push_r),
    .in_ready(fifo_in_ready),
    .in_data(rx_sh_r),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      overrun_r <= 1'b0;
    end else if (rx_push_r && !fifo_in_ready) begin
      overrun_r <= 1'b1;
    end
  end

  // ==========================================
  // Sequencer
  always_comb begin
    fifo_pop = 1'b0;
    tx_start = 1'b0;
    tx_byte = fifo_data;
    case (state_r)
      sbp_pkg::SBP_SYNC: fifo_pop = fifo_valid;
      sbp_pkg::SBP_LOAD: begin
        fifo_pop = fifo_valid && !tx_busy_r;
        tx_start = fifo_pop;
      end
      sbp_pkg::SBP_PROG: fifo_pop = fifo_valid && !wr_r;
      sbp_pkg::SBP_SEND: begin
        tx_start = !tx_busy_r;
        tx_byte = rb_r;
      end
      default: fifo_pop = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= sbp_pkg::SBP_SYNC;
      load_cnt_r <= '0;
    end else begin
      case (state_r)
        sbp_pkg::SBP_SYNC: begin
          if (fifo_pop && fifo_data == `SBP_SYNC_BYTE) begin
            state_r <= sbp_pkg::SBP_LOAD;
            load_cnt_r <= '0;
          end
        end
        sbp_pkg::SBP_LOAD: begin
          if (fifo_pop) begin
            load_cnt_r <= load_cnt_r + 1'b1;
            if (load_cnt_r == `SBP_CNT_W'(LOADER_LEN - 1)) begin
              state_r <= sbp_pkg::SBP_SETUP;
            end
          end
        end
        sbp_pkg::SBP_SETUP: state_r <= sbp_pkg::SBP_PROG;
        sbp_pkg::SBP_PROG: begin
          if (wr_r && nvm_ack) begin
            state_r <= sbp_pkg::SBP_READ;
          end
        end
        sbp_pkg::SBP_READ: begin
          if (rd_r && nvm_ack) begin
            state_r <= sbp_pkg::SBP_SEND;
          end
        end
        sbp_pkg::SBP_SEND: begin
          if (tx_start) begin
            state_r <= sbp_pkg::SBP_PROG;
          end
        end
        default: state_r <= sbp_pkg::SBP_SYNC;
      endcase
    end
  end

  // ==========================================
  // Programming port and indicator
  always_ff @(posedge clk) begin
    if (srst) begin
      portc0_r <= 1'b1;
      prog_active_r <= 1'b0;
      addr_r <= '0;
      wdata_r <= '0;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      rb_r <= '0;
    end else begin
      if (state_r == sbp_pkg::SBP_SETUP) begin
        portc0_r <= 1'b0;
        prog_active_r <= 1'b1;
        addr_r <= `SBP_PROG_BASE;
      end
      if (state_r == sbp_pkg::SBP_PROG && fifo_pop) begin
        wdata_r <= fifo_data;
        wr_r <= 1'b1;
      end else if (wr_r && nvm_ack) begin
        wr_r <= 1'b0;
        rd_r <= 1'b1;
      end else if (rd_r && nvm_ack) begin
        rd_r <= 1'b0;
        rb_r <= nvm_rdata;
      end
      if (state_r == sbp_pkg::SBP_SEND && tx_start) begin
        addr_r <= addr_r + 1'b1;
      end
    end
  end

  // ==========================================
  // Transmitter, shared by echo and read-back
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_busy_r <= 1'b0;
      tx_ph_r <= '0;
      tx_bit_r <= '0;
      tx_sh_r <= '0;
      tx_data_r <= '0;
      txd_r <= 1'b1;
    end else if (tx_start) begin
      tx_busy_r <= 1'b1;
      tx_ph_r <= '0;
      tx_bit_r <= '0;
      tx_sh_r <= {1'b1, tx_byte};
      tx_data_r <= tx_byte;
      txd_r <= 1'b0;
    end else if (tx_busy_r && tick) begin
      tx_ph_r <= tx_ph_r + 1'b1;
      if (tx_ph_r == 4'hF) begin
        tx_bit_r <= tx_bit_r + 1'b1;
        if (tx_bit_r == 4'h9) begin
          tx_busy_r <= 1'b0;
          txd_r <= 1'b1;
        end else begin
          txd_r <= tx_sh_r[0];
          tx_sh_r <= {1'b0, tx_sh_r[8:1]};
        end
      end
    end
  end

  // ==========================================
  // Checks
  chk_echo_byte: assert property (@(posedge clk) disable iff (srst)
    (state_r == sbp_pkg::SBP_LOAD && fifo_pop) |=> (tx_busy_r && !txd_r && tx_data_r == $past(fifo_data)))
    else $error("loader byte not echoed");
  chk_auto_run: assert property (@(posedge clk) disable iff (srst)
    (state_r == sbp_pkg::SBP_LOAD && fifo_pop && load_cnt_r == `SBP_CNT_W'(LOADER_LEN - 1))
    |=> state_r == sbp_pkg::SBP_SETUP ##1 state_r == sbp_pkg::SBP_PROG)
    else $error("loader did not start by itself");
  chk_setup_port: assert property (@(posedge clk) disable iff (srst)
    (state_r == sbp_pkg::SBP_SETUP) |=> (!portc0_r && prog_active_r && addr_r == `SBP_PROG_BASE))
    else $error("setup did not drive port low or set address");
  chk_port_stays: assert property (@(posedge clk) disable iff (srst)
    (state_r == sbp_pkg::SBP_SYNC || state_r == sbp_pkg::SBP_LOAD) |-> portc0_r)
    else $error("port bit low before loader ran");
  chk_write_read: assert property (@(posedge clk) disable iff (srst)
    (wr_r && nvm_ack) |=> (rd_r && !wr_r && state_r == sbp_pkg::SBP_READ))
    else $error("no read after program");
  chk_readback_tx: assert property (@(posedge clk) disable iff (srst)
    (rd_r && nvm_ack) |=> (rb_r == $past(nvm_rdata) && state_r == sbp_pkg::SBP_SEND))
    else $error("read-back value not held for sending");
  // Cycles spent waiting for the transmitter to free up
  logic [31:0] send_wait_r;
  always_ff @(posedge clk) begin
    send_wait_r <= (srst || state_r != sbp_pkg::SBP_SEND) ? '0 : send_wait_r + 32'h00000001;
  end
  chk_send_bound: assert property (@(posedge clk) disable iff (srst)
    (state_r == sbp_pkg::SBP_SEND) |-> (send_wait_r < 32'(10 * 16 * TICK_DIV + 4)))
    else $error("read-back not sent within one frame");
endmodule
`default_nettype wire

// file: rtl/sbp_defines.svh
// Constants for the serial boot and programming engine
// What this block does
// - Echo every loader byte received
// - Enter loader automatically after last byte
// - Drive port bit low, set address, program
// - Receiver holds bytes while next one arrives
// - Read back each programmed byte, send it
`ifndef SBP_DEFINES_SVH
`define SBP_DEFINES_SVH

// ==========================================
// Timing
`define SBP_CLK_HZ 100000000
`define SBP_BAUD 1200
`define SBP_OVERSAMPLE 16
`define SBP_TICK_CYCLES (`SBP_CLK_HZ / (`SBP_BAUD * `SBP_OVERSAMPLE))
`define SBP_TICK_W 13

// ==========================================
// Session layout
`define SBP_SYNC_BYTE 8'hFF
`define SBP_LOADER_LEN 25
`define SBP_CNT_W 8
`define SBP_PROG_BASE 16'h0000
`define SBP_ADDR_W 16
`define SBP_DATA_W 8
`define SBP_FIFO_DEPTH 4

`endif

// file: rtl/sbp_pkg.sv
// Types for the serial boot and programming engine
`default_nettype none
package sbp_pkg;
  typedef enum logic [2:0] {
    SBP_SYNC = 3'b000,
    SBP_LOAD = 3'b001,
    SBP_SETUP = 3'b010,
    SBP_PROG = 3'b011,
    SBP_READ = 3'b100,
    SBP_SEND = 3'b101
  } sbp_state_t;
endpackage
`default_nettype wire

// file: rtl/sbp_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module sbp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [PW:0] count_r;
  logic push;
  logic pop;

  assign in_ready = (count_r != (PW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem[rd_ptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == PW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == PW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

  // ==========================================
  // Checks
  chk_full_refuse: assert property (@(posedge clk) disable iff (srst)
    (count_r == (PW+1)'(DEPTH)) |-> !in_ready) else $error("fifo accepts while full");
  chk_hold_count: assert property (@(posedge clk) disable iff (srst)
    (push && !pop) |=> (count_r == $past(count_r) + 1'b1)) else $error("fifo lost a byte");
endmodule
`default_nettype wire

// file: verif/sbp_host_model.sv
// Host computer model on the asynchronous serial port
`timescale 1ns/10ps
`default_nettype none
module sbp_host_model #(
  parameter int BIT = 64,
  parameter logic [15:0] IMG_BASE = 16'h1000
) (
  input wire logic clk,
  output logic line_o,
  input wire logic line_i
);
  // ==========================================
  // Serial frames, 8N1, LSB first
  initial line_o = 1'b1;

  // ==========================================
  // Image built from object records
  logic [7:0] image [0:15];

  // Payload holds up to four data bytes, first byte in the low bits
  task automatic take_record(input logic [3:0] rtype, input logic [7:0] cnt, input logic [15:0] load_addr,
                             input logic [31:0] payload);
    logic [15:0] idx;
    idx = load_addr - IMG_BASE;
    if (rtype == 4'h1) begin
      for (int i = 0; i < int'(cnt) - 3; i++) begin
        image[idx[3:0] + 4'(i)] = payload[8*i +: 8];
      end
    end
  endtask

  // Stop bit leaves the line at its idle high level
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_o <= f[i];
      repeat (BIT) @(posedge clk);
    end
  endtask

  // Returns at mid stop bit so a following frame is not missed
  task automatic recv_byte(output logic [7:0] b);
    @(posedge clk);
    while (line_i !== 1'b0) @(posedge clk);
    repeat (BIT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk);
      b[i] = line_i;
    end
    repeat (BIT) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// file: verif/sbp_tb_top.sv
// Self-checking testbench for the serial boot and programming engine
`timescale 1ns/10ps
`default_nettype none
`include "sbp_defines.svh"
module sbp_tb_top;
  localparam int TD = 4;
  localparam int BIT = 16 * TD;
  localparam logic [7:0] IMG [3] = '{8'h5A, 8'hC3, 8'h0F};
  logic clk = 1'b0;
  logic srst;
  logic rxd;
  logic txd;
  logic portc0;
  logic prog_active;
  logic rx_overrun;
  logic nvm_wr;
  logic nvm_rd;
  logic nvm_ack;
  logic stall = 1'b0;
  logic [15:0] nvm_addr;
  logic [7:0] nvm_wdata;
  logic [7:0] nvm_rdata;
  logic [7:0] mem [0:15];
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int wcnt = 0;
  int nver = 0;

  always #5 clk = ~clk;

  sbp_top #(.TICK_DIV(TD), .LOADER_LEN(2)) dut (
    .clk(clk), .srst(srst), .rxd(rxd), .txd(txd), .portc0(portc0),
    .prog_active(prog_active), .rx_overrun(rx_overrun), .nvm_addr(nvm_addr),
    .nvm_wdata(nvm_wdata), .nvm_wr(nvm_wr), .nvm_rd(nvm_rd),
    .nvm_rdata(nvm_rdata), .nvm_ack(nvm_ack)
  );

  sbp_host_model #(.BIT(BIT), .IMG_BASE(16'h1000)) host (.clk(clk), .line_o(rxd), .line_i(txd));

  // ==========================================
  // Memory model: acks after three cycles, read data churns on every cycle that gives no ack
  always @(posedge clk) begin
    if (srst) begin
      nvm_ack <= 1'b0;
      nvm_rdata <= 8'h00;
      wcnt <= 0;
    end else if ((nvm_wr || nvm_rd) && !nvm_ack && !stall && wcnt == 2) begin
      nvm_ack <= 1'b1;
      wcnt <= 0;
      if (nvm_wr) mem[nvm_addr[3:0]] <= nvm_wdata;
      nvm_rdata <= mem[nvm_addr[3:0]];
    end else begin
      nvm_ack <= 1'b0;
      nvm_rdata <= ~nvm_rdata;
      if ((nvm_wr || nvm_rd) && !nvm_ack && !stall) wcnt <= wcnt + 1;
    end
  end

  // ==========================================
  // Checking and closing
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      num_errors++;
      give_verdict;
    end
  end

  // ==========================================
  // Scenarios
  task automatic test_sync_loader;
    logic [7:0] e0;
    logic [7:0] e1;
    check("portc0 reset", portc0, 16'h0001);
    check("prog_active reset", prog_active, 16'h0000);
    host.send_byte(8'h12);
    repeat (4) @(posedge clk);
    check("no echo before sync", txd, 16'h0001);
    host.send_byte(`SBP_SYNC_BYTE);
    fork
      begin
        host.send_byte(8'hA5);
        host.send_byte(8'h3C);
      end
      begin
        host.recv_byte(e0);
        host.recv_byte(e1);
      end
    join
    check("echo 0", e0, 16'h00A5);
    check("echo 1", e1, 16'h003C);
    repeat (4) @(posedge clk);
    check("portc0 loader", portc0, 16'h0000);
    check("prog_active", prog_active, 16'h0001);
    check("start address", nvm_addr, `SBP_PROG_BASE);
    $display("test sync_loader done");
  endtask

  task automatic test_program;
    logic [7:0] rb;
    host.take_record(4'h1, 8'h05, 16'h1000, 32'h0000C35A);
    host.take_record(4'h1, 8'h04, 16'h1002, 32'h0000000F);
    host.take_record(4'h9, 8'h05, 16'h1000, 32'h0000EEEE);
    for (int k = 0; k < 3; k++) check("image", {8'h00, host.image[k]}, {8'h00, IMG[k]});
    nver = 0;
    fork
      begin
        host.send_byte(host.image[0]);
        host.send_byte(host.image[1]);
        wait (nver >= 1);
        @(posedge clk);
        host.send_byte(host.image[2]);
      end
      for (int k = 0; k < 3; k++) begin
        host.recv_byte(rb);
        check("readback", {8'h00, rb}, {8'h00, IMG[k]});
        nver++;
      end
    join
    for (int k = 0; k < 3; k++) check("stored", {8'h00, mem[k]}, {8'h00, IMG[k]});
    check("address after three", nvm_addr, `SBP_PROG_BASE + 16'h0003);
    $display("test program done");
  endtask

  task automatic test_overrun;
    stall <= 1'b1;
    repeat (5) host.send_byte(8'h77);
    repeat (4) @(posedge clk);
    check("no overrun at four queued", rx_overrun, 16'h0000);
    check("write held while stalled", nvm_wr, 16'h0001);
    host.send_byte(8'h77);
    repeat (4) @(posedge clk);
    check("overrun on fifth queued", rx_overrun, 16'h0001);
    $display("test overrun done");
  endtask

  task automatic test_reset_again;
    srst <= 1'b1;
    stall <= 1'b0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    check("overrun cleared by reset", rx_overrun, 16'h0000);
    check("portc0 after reset", portc0, 16'h0001);
    check("write dropped by reset", nvm_wr, 16'h0000);
    check("address after reset", nvm_addr, 16'h0000);
    $display("test reset_again done");
  endtask

  initial begin
    srst <= 1'b1;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    test_sync_loader();
    test_program();
    test_overrun();
    test_reset_again();
    give_verdict();
  end
endmodule
`default_nettype wire
